// File: logic/and_exec_pkg.sv
`default_nettype none
package and_exec_pkg;
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int OPC_W = 6;
    localparam logic [5:0] OPC_AND_LIT = 6'h39;
    localparam logic [5:0] OPC_AND_FILE = 6'h05;
    localparam int OPC_LSB = 8;
    localparam int DEST_BIT = 7;
    localparam int LIT_LSB = 0;
    localparam int ADDR_LSB = 0;
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic ZERO_RST = 1'b0;
    localparam logic [6:0] WADDR_RST = 7'h00;
    localparam logic [7:0] WDATA_RST = 8'h00;
    localparam logic DEST_WORK = 1'b0;
    localparam logic DEST_FILE = 1'b1;
endpackage
`default_nettype wire

// File: logic/and_decode.sv
`timescale 1ns/10ps
`default_nettype none
module and_decode (
    input wire logic [and_exec_pkg::INSTR_W-1:0] instr,
    output logic is_lit,
    output logic is_file,
    output logic dest_file,
    output logic [and_exec_pkg::DATA_W-1:0] literal,
    output logic [and_exec_pkg::ADDR_W-1:0] file_addr
);
    import and_exec_pkg::*;

    function automatic logic opcode_is(
        input logic [OPC_W-1:0] op,
        input logic [OPC_W-1:0] code
    );
        return op == code;
    endfunction

    wire [OPC_W-1:0] opcode;
    assign opcode = instr[INSTR_W-1:OPC_LSB];
    assign is_lit = opcode_is(opcode, OPC_AND_LIT);
    assign is_file = opcode_is(opcode, OPC_AND_FILE);
    assign dest_file = instr[DEST_BIT];
    assign literal = instr[LIT_LSB +: DATA_W];
    assign file_addr = instr[ADDR_LSB +: ADDR_W];
endmodule
`default_nettype wire

// File: logic/logical_and_instr_exec.sv
`timescale 1ns/10ps
`default_nettype none
module logical_and_instr_exec (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire logic [and_exec_pkg::INSTR_W-1:0] instr,
    input wire logic [and_exec_pkg::DATA_W-1:0] file_rdata,
    input wire logic work_load,
    input wire logic [and_exec_pkg::DATA_W-1:0] work_load_data,
    output logic [and_exec_pkg::ADDR_W-1:0] file_raddr,
    output logic file_we,
    output logic [and_exec_pkg::ADDR_W-1:0] file_waddr,
    output logic [and_exec_pkg::DATA_W-1:0] file_wdata,
    output logic [and_exec_pkg::DATA_W-1:0] work,
    output logic zero_flag,
    output logic done
);
    import and_exec_pkg::*;

    // bitwise product shared by both instructions
    function automatic logic [DATA_W-1:0] and_bytes(
        input logic [DATA_W-1:0] lhs,
        input logic [DATA_W-1:0] rhs
    );
        return lhs & rhs;
    endfunction

    function automatic logic is_zero(
        input logic [DATA_W-1:0] val
    );
        return val == '0;
    endfunction

    // decoded fields of the current word
    logic is_lit;
    logic is_file;
    logic dest_file;
    logic [DATA_W-1:0] literal;
    logic [ADDR_W-1:0] addr;

    // registered state and its next values
    logic [DATA_W-1:0] work_q;
    logic [DATA_W-1:0] work_d;
    logic zero_q;
    logic zero_d;
    logic we_q;
    logic we_d;
    logic [ADDR_W-1:0] waddr_q;
    logic [ADDR_W-1:0] waddr_d;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] wdata_d;
    logic done_q;
    logic done_d;

    and_decode u_dec (
        .instr(instr),
        .is_lit(is_lit),
        .is_file(is_file),
        .dest_file(dest_file),
        .literal(literal),
        .file_addr(addr)
    );

    // read address is combinational so the file data arrives in the same cycle
    assign file_raddr = addr;

    wire exec_lit;
    wire exec_file;
    wire exec_any;
    wire load_work;
    wire fwd_hit;
    wire [DATA_W-1:0] file_value;
    wire [DATA_W-1:0] operand;
    wire [DATA_W-1:0] result;
    wire to_work;
    wire to_file;

    assign exec_lit = instr_valid && is_lit;
    assign exec_file = instr_valid && is_file;
    assign exec_any = exec_lit || exec_file;
    // a write issued last cycle lands only at this edge, so the file still
    // shows the old byte; back-to-back ops on one register take the pending one
    assign fwd_hit = we_q && (waddr_q == addr);
    assign file_value = fwd_hit ? wdata_q : file_rdata;
    assign operand = exec_lit ? literal : file_value;
    assign result = and_bytes(work_q, operand);
    assign to_work = exec_lit || (exec_file && dest_file == DEST_WORK);
    assign to_file = exec_file && dest_file == DEST_FILE;
    // an AND owns the work register in its cycle; a clashing load is dropped
    assign load_work = work_load && !exec_any;

    assign work_d = to_work ? result : (load_work ? work_load_data : work_q);
    // other status flags live outside; only zero is touched here
    assign zero_d = exec_any ? is_zero(result) : zero_q;
    assign we_d = to_file;
    // address and data stand until the next valid word
    assign waddr_d = instr_valid ? addr : waddr_q;
    assign wdata_d = instr_valid ? result : wdata_q;
    assign done_d = exec_any;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            work_q <= WORK_RST;
        end else begin
            work_q <= work_d;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            zero_q <= ZERO_RST;
        end else begin
            zero_q <= zero_d;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            we_q <= 1'b0;
        end else begin
            we_q <= we_d;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            waddr_q <= WADDR_RST;
        end else begin
            waddr_q <= waddr_d;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wdata_q <= WDATA_RST;
        end else begin
            wdata_q <= wdata_d;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_d;
        end
    end

    assign work = work_q;
    assign zero_flag = zero_q;
    assign file_we = we_q;
    assign file_waddr = waddr_q;
    assign file_wdata = wdata_q;
    assign done = done_q;
endmodule
`default_nettype wire

// File: tb/and_exec_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module and_exec_chk (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire logic [13:0] instr,
    input wire logic [7:0] file_rdata,
    input wire logic file_we,
    input wire logic [6:0] file_waddr,
    input wire logic [7:0] file_wdata,
    input wire logic [7:0] work,
    input wire logic zero_flag,
    input wire logic done,
    input wire logic work_load
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire l = instr_valid && instr[13:8] == 6'h39;
    wire f = instr_valid && instr[13:8] == 6'h05;
    // a write still pending from last cycle is what the file really holds
    wire hit = file_we && file_waddr == instr[6:0];
    wire [7:0] fv = hit ? file_wdata : file_rdata;
    wire [7:0] r = l ? work & instr[7:0] : work & fv;
    wire idle = !(l || f) && !work_load;
    AST_LIT: assert property (l |=> work == $past(r))
        else $error("lit");
    AST_WK: assert property (f && !instr[7] |=> work == $past(r) && !file_we)
        else $error("wk");
    AST_FL: assert property (f && instr[7] |=>
        file_we && file_wdata == $past(r) && $stable(work))
        else $error("fl");
    AST_ZF: assert property (l || f |=> zero_flag == ($past(r) == 8'h00))
        else $error("zf");
    AST_DN: assert property (l || f |=> done)
        else $error("dn");
    AST_NO: assert property (!(l || f) |=> !done && !file_we)
        else $error("no");
    AST_HOLD: assert property (idle |=> $stable(work) && $stable(zero_flag))
        else $error("hold");
endmodule
bind logical_and_instr_exec and_exec_chk i_chk (
    .clock(clock),
    .sys_rst(sys_rst),
    .instr_valid(instr_valid),
    .instr(instr),
    .file_rdata(file_rdata),
    .file_we(file_we),
    .file_waddr(file_waddr),
    .file_wdata(file_wdata),
    .work(work),
    .zero_flag(zero_flag),
    .done(done),
    .work_load(work_load)
);
`default_nettype wire

// File: tb/logical_and_instr_exec_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module logical_and_instr_exec_tb_top;
    logic clock = 0, sys_rst = 1, instr_valid = 0, file_we, zero_flag, done;
    logic work_load = 0;
    logic [13:0] instr = 0;
    logic [7:0] file_rdata = 0, file_wdata, work;
    logic [7:0] work_load_data = 0;
    logic [6:0] file_raddr, file_waddr;
    int num_errors = 0, comparisons = 0;
    wire [10:0] st = {work, zero_flag, done, file_we};
    logical_and_instr_exec i_dut (
        .clock(clock),
        .sys_rst(sys_rst),
        .instr_valid(instr_valid),
        .instr(instr),
        .file_rdata(file_rdata),
        .work_load(work_load),
        .work_load_data(work_load_data),
        .file_raddr(file_raddr),
        .file_we(file_we),
        .file_waddr(file_waddr),
        .file_wdata(file_wdata),
        .work(work),
        .zero_flag(zero_flag),
        .done(done)
    );
    initial forever #20 clock = ~clock;
    task chk(input logic [10:0] g, input logic [10:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task run(input logic [13:0] i, input logic v, input logic [7:0] d);
        @(posedge clock) #1;
        {instr, instr_valid, file_rdata} = {i, v, d};
        #1 chk({4'h0, file_raddr}, {4'h0, i[6:0]});
        @(posedge clock) #1;
        instr_valid = 1'b0;
    endtask
    task load(input logic [7:0] w);
        @(posedge clock) #1;
        {work_load, work_load_data} = {1'b1, w};
        @(posedge clock) #1;
        work_load = 1'b0;
    endtask
    task t_ops;
        load(8'ha3);
        run(14'h395f, 1'b1, 8'hff);
        chk(st, 11'h01a);
        run(14'h052a, 1'b1, 8'h01);
        chk(st, 11'h00a);
        run(14'h39fe, 1'b1, 8'hff);
        chk(st, 11'h006);
        load(8'hc3);
        run(14'h05ff, 1'b1, 8'h5a);
        chk(st, 11'h61b);
        chk({4'h0, file_waddr}, 11'h07f);
        chk({3'h0, file_wdata}, 11'h042);
        $display("ops end");
    endtask
    task t_refuse;
        run(14'h0700, 1'b1, 8'hff);
        chk(st, 11'h618);
        run(14'h395f, 1'b0, 8'hff);
        chk(st, 11'h618);
        $display("refuse end");
    endtask
    task t_b2b;
        load(8'ha3);
        @(posedge clock) #1;
        {instr, instr_valid, file_rdata} = {14'h0590, 1'b1, 8'hff};
        @(posedge clock) #1;
        {instr, file_rdata} = {14'h0510, 8'h0f};
        chk(st, 11'h51b);
        @(posedge clock) #1;
        instr_valid = 1'b0;
        chk(st, 11'h51a);
        $display("b2b end");
    endtask
    initial begin
        repeat (16) @(posedge clock);
        #1 sys_rst = 0;
        chk(st, 11'h000);
        t_ops;
        t_refuse;
        t_b2b;
        finish_test;
    end
    initial begin
        #4000;
        num_errors++;
        finish_test;
    end
endmodule
`default_nettype wire
